// [tmcc_edge.sv]
// edge detector for the timer input pins
// assumes the pins are already synchronous to clk
`timescale 1ns/100ps
`default_nettype none
module tmcc_edge (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] pin,
   tmcc_evt_if.edge_det evt
);
   logic [1:0] prev_q;

   // previous level, low after reset so a high pin gives one rise
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prev_q <= 2'h0;
      end else begin
         prev_q <= pin;
      end
   end

   // strobes are combinational so the core sees them in the edge cycle
   assign evt.rise = pin & ~prev_q;
   assign evt.fall = ~pin & prev_q;
endmodule : tmcc_edge
`default_nettype wire

// [tmcc_evt_if.sv]
// count tick and pin edge strobes passed from the helper modules to the core
// assumes all parties run on the one system clock
`timescale 1ns/100ps
`default_nettype none
interface tmcc_evt_if;
   logic tick;
   logic [1:0] rise;
   logic [1:0] fall;
   modport presc (output tick);
   modport edge_det (output rise, output fall);
   modport core (input tick, input rise, input fall);
endinterface : tmcc_evt_if
`default_nettype wire

// [tmcc_pin_src.sv]
// stand-in for the external timer input pins
// assumes the bench asks for pin levels on rising clock edges
`timescale 1ns/100ps
`default_nettype none
module tmcc_pin_src (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] lvl_req,
   output logic [1:0] pin_q
);
   // registered, so the pins stay synchronous to clk as the design expects
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         pin_q <= 2'h0;
      end else begin
         pin_q <= lvl_req;
      end
   end
endmodule : tmcc_pin_src
`default_nettype wire

// [tmcc_pkg.sv]
// types shared by the timer channel block
// assumes nothing beyond a systemverilog compiler
package tmcc_pkg;
   typedef enum logic [2:0] {
      TMCC_IDLE = 3'b001,
      TMCC_WAIT = 3'b010,
      TMCC_RUN = 3'b100
   } tmcc_state_t;
   typedef enum logic [2:0] {
      TMCC_OP_INTERVAL = 3'b000,
      TMCC_OP_CAPTURE = 3'b010,
      TMCC_OP_ONECOUNT = 3'b100,
      TMCC_OP_CAPONE = 3'b110
   } tmcc_op_t;
   typedef enum logic [2:0] {
      TMCC_TRIG_SW = 3'b000,
      TMCC_TRIG_EDGE = 3'b001,
      TMCC_TRIG_BOTH = 3'b010,
      TMCC_TRIG_MASTER = 3'b100
   } tmcc_trig_t;
endpackage : tmcc_pkg

// [tmcc_presc.sv]
// prescaler: one tick every 2**sel clocks
// assumes sel is stable while counting, a change only shifts the next tick
`timescale 1ns/100ps
`default_nettype none
module tmcc_presc (
   input wire logic clk,
   input wire logic reset,
   input wire logic [3:0] div_sel,
   tmcc_evt_if.presc evt
);
   logic [15:0] div_q;
   logic tick_q;
   logic [15:0] mask;

   // low bits below the selected power must all be ones
   assign mask = 16'(({16'h0000, 16'h0001} << div_sel) - 32'h0000_0001);

   // free running divider, ticks registered to keep the core path short
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_q + 16'h0001;
         tick_q <= &(div_q | ~mask);
      end
   end

   assign evt.tick = tick_q;
endmodule : tmcc_presc
`default_nettype wire

// [tmcc_regs.svh]
// register indices, field positions and reset values of the timer channel block
// assumes the includer sits on a 32-bit apb bus, byte address = four times the index
// Behaviour
// - split bit set gives 8-bit counting
// - trigger code 000: software start only
// - code 001: valid pin edge starts, captures
// - code 010: both pin edges start, capture
// - code 100: master interrupt triggers; others prohibited
// - mode 000x: interval timer, counts down
// - mode 010x: capture, counts up
// - mode 100x: one-count, counts down
// - mode 1100: capture and one-count, up
// - start bit clear: no start interrupt
// - start bit set: interrupt, toggle on start; the code does this in interval and capture modes only, not one-count
// - start write one sets enable status
// - 16-bit data register, resets to zero
// - stop write one halts the channel
// - clock select one counts pin edges
`ifndef TMCC_REGS_SVH
`define TMCC_REGS_SVH
`define TMCC_IDX_START 20'hF01B2
`define TMCC_IDX_STOP 20'hF01B4
`define TMCC_IDX_PRESC 20'hF01B6
`define TMCC_IDX_MODE1 20'hF0192
`define TMCC_IDX_MODE3 20'hF0196
`define TMCC_IDX_DATA1 20'hFFF1A
`define TMCC_IDX_DATA3 20'hFFF66
`define TMCC_IDX_ENSTAT 20'hF01C0
`define TMCC_IDX_IRQST 20'hF01C2
`define TMCC_IDX_IRQMSK 20'hF01C4
`define TMCC_IDX_CNT1 20'hF01C6
`define TMCC_IDX_CNT3 20'hF01C8
`define TMCC_CH1_BIT 1
`define TMCC_CH3_BIT 3
`define TMCC_MD_CCS 12
`define TMCC_MD_SPLIT 11
`define TMCC_MD_TRIG_HI 10
`define TMCC_MD_TRIG_LO 8
`define TMCC_MD_EDGE 6
`define TMCC_MD_OP_HI 3
`define TMCC_MD_OP_LO 1
`define TMCC_MD_SIRQ 0
`define TMCC_RST_REG16 16'h0000
`define TMCC_RST_PRESC 4'h0
`define TMCC_RST_IRQ 2'h0
`endif

// [tmcc_top.sv]
// two timer channels with mode control, apb register file and interrupt
// assumes an apb3 master, synchronous timer input pins and one 25 mhz clock
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "tmcc_regs.svh"
module tmcc_top
   import tmcc_pkg::*;
#(
   parameter int ADDR_W = 24
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [1:0] timer_input_pin,
   input wire logic master_irq_in,
   output logic [1:0] timer_out,
   output logic irq
);
   localparam int CH_BIT [2] = '{`TMCC_CH1_BIT, `TMCC_CH3_BIT};
   localparam logic [19:0] DATA_IDX [2] = '{`TMCC_IDX_DATA1, `TMCC_IDX_DATA3};

   tmcc_evt_if evt ();

   logic [15:0] mode_q [2];
   logic [15:0] data_q [2];
   logic [15:0] cnt_q [2];
   tmcc_state_t state_q [2];
   logic [1:0] en_q;
   logic [1:0] tout_q;
   logic [1:0] evt_q;
   logic [1:0] st_q;
   logic [1:0] msk_q;
   logic [3:0] presc_q;
   logic [31:0] prdata_q;
   logic slverr_q;
   logic [31:0] rd_data;
   logic rd_hit;
   logic wr_go;
   logic [1:0] sw_start;
   logic [1:0] sw_stop;
   logic [1:0] wr_data;
   logic [2:0] trig_f [2];
   logic [2:0] op_f [2];
   logic [1:0] split;
   logic [1:0] sirq;
   logic [1:0] valid_edge;
   logic [1:0] opp_edge;
   logic [1:0] master_src;
   logic [1:0] trig_hit;
   logic [1:0] cnt_tick;
   logic [1:0] legal;
   logic [1:0] zero;
   logic [1:0] start_evt;
   logic [15:0] init_val [2];

   function automatic logic idx_hit(input logic [ADDR_W-1:0] a, input logic [19:0] idx);
      return a == {{(ADDR_W-22){1'b0}}, idx, 2'b00};
   endfunction : idx_hit

   // reload value, upper byte forced to zero in 8-bit operation
   function automatic logic [15:0] load_val(input logic [15:0] d, input logic sp);
      return sp ? {8'h00, d[7:0]} : d;
   endfunction : load_val

   // up count step, 8-bit operation wraps within the low byte
   function automatic logic [15:0] step_up(input logic [15:0] c, input logic sp);
      logic [15:0] n;
      n = c + 16'h0001;
      return sp ? {8'h00, n[7:0]} : n;
   endfunction : step_up

   tmcc_presc u_presc (
      .clk(clk),
      .reset(reset),
      .div_sel(presc_q),
      .evt(evt)
   );

   tmcc_edge u_edge (
      .clk(clk),
      .reset(reset),
      .pin(timer_input_pin),
      .evt(evt)
   );

   // channel 3 is slaved to the registered interrupt pulse of channel 1
   assign master_src = {evt_q[0], master_irq_in};

   // per channel decode of the mode fields and trigger sources
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         trig_f[i] = mode_q[i][`TMCC_MD_TRIG_HI:`TMCC_MD_TRIG_LO];
         op_f[i] = mode_q[i][`TMCC_MD_OP_HI:`TMCC_MD_OP_LO];
         split[i] = mode_q[i][`TMCC_MD_SPLIT];
         sirq[i] = mode_q[i][`TMCC_MD_SIRQ];
         valid_edge[i] = mode_q[i][`TMCC_MD_EDGE] ? evt.rise[i] : evt.fall[i];
         opp_edge[i] = mode_q[i][`TMCC_MD_EDGE] ? evt.fall[i] : evt.rise[i];
         unique case (trig_f[i])
            TMCC_TRIG_EDGE: trig_hit[i] = valid_edge[i];
            TMCC_TRIG_BOTH: trig_hit[i] = evt.rise[i] | evt.fall[i];
            TMCC_TRIG_MASTER: trig_hit[i] = master_src[i];
            default: trig_hit[i] = 1'b0;
         endcase
         cnt_tick[i] = mode_q[i][`TMCC_MD_CCS] ? valid_edge[i] : evt.tick;
         // event counter and other codes leave the channel frozen
         legal[i] = (op_f[i] == TMCC_OP_INTERVAL) || (op_f[i] == TMCC_OP_CAPTURE) ||
                    (op_f[i] == TMCC_OP_ONECOUNT) || (op_f[i] == TMCC_OP_CAPONE && !sirq[i]);
         zero[i] = split[i] ? (cnt_q[i][7:0] == 8'h00) : (cnt_q[i] == 16'h0000);
         start_evt[i] = sirq[i] && (op_f[i] == TMCC_OP_INTERVAL || op_f[i] == TMCC_OP_CAPTURE);
         init_val[i] = (op_f[i] == TMCC_OP_CAPTURE || op_f[i] == TMCC_OP_CAPONE) ?
                       16'h0000 : load_val(data_q[i], split[i]);
      end
   end

   // read mux and address decode
   always_comb begin
      rd_data = 32'h0000_0000;
      rd_hit = 1'b1;
      if (idx_hit(paddr, `TMCC_IDX_START) || idx_hit(paddr, `TMCC_IDX_STOP)) begin
         rd_data = 32'h0000_0000;
      end else if (idx_hit(paddr, `TMCC_IDX_PRESC)) begin
         rd_data = {28'h0000000, presc_q};
      end else if (idx_hit(paddr, `TMCC_IDX_MODE1)) begin
         rd_data = {16'h0000, mode_q[0]};
      end else if (idx_hit(paddr, `TMCC_IDX_MODE3)) begin
         rd_data = {16'h0000, mode_q[1]};
      end else if (idx_hit(paddr, `TMCC_IDX_DATA1)) begin
         rd_data = {16'h0000, data_q[0]};
      end else if (idx_hit(paddr, `TMCC_IDX_DATA3)) begin
         rd_data = {16'h0000, data_q[1]};
      end else if (idx_hit(paddr, `TMCC_IDX_ENSTAT)) begin
         rd_data = {28'h0000000, en_q[1], 1'b0, en_q[0], 1'b0};
      end else if (idx_hit(paddr, `TMCC_IDX_IRQST)) begin
         rd_data = {30'h00000000, st_q};
      end else if (idx_hit(paddr, `TMCC_IDX_IRQMSK)) begin
         rd_data = {30'h00000000, msk_q};
      end else if (idx_hit(paddr, `TMCC_IDX_CNT1)) begin
         rd_data = {16'h0000, cnt_q[0]};
      end else if (idx_hit(paddr, `TMCC_IDX_CNT3)) begin
         rd_data = {16'h0000, cnt_q[1]};
      end else begin
         rd_hit = 1'b0;
      end
   end

   // write strobes, taken only at the access edge of a mapped address
   assign wr_go = psel && penable && pwrite && rd_hit;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         sw_start[i] = wr_go && idx_hit(paddr, `TMCC_IDX_START) && pwdata[CH_BIT[i]];
         sw_stop[i] = wr_go && idx_hit(paddr, `TMCC_IDX_STOP) && pwdata[CH_BIT[i]];
         wr_data[i] = wr_go && idx_hit(paddr, DATA_IDX[i]);
      end
   end

   // read data latched in the setup cycle, so the slave never waits
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         prdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end else if (psel && !penable) begin
         prdata_q <= rd_data;
         slverr_q <= !rd_hit;
      end
   end

   assign prdata = prdata_q;
   assign pslverr = slverr_q;
   assign pready = 1'b1;

   // plain configuration registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         mode_q[0] <= `TMCC_RST_REG16;
         mode_q[1] <= `TMCC_RST_REG16;
         presc_q <= `TMCC_RST_PRESC;
         msk_q <= `TMCC_RST_IRQ;
      end else begin
         if (wr_go && idx_hit(paddr, `TMCC_IDX_MODE1)) mode_q[0] <= pwdata[15:0];
         if (wr_go && idx_hit(paddr, `TMCC_IDX_MODE3)) mode_q[1] <= pwdata[15:0];
         if (wr_go && idx_hit(paddr, `TMCC_IDX_PRESC)) presc_q <= pwdata[3:0];
         if (wr_go && idx_hit(paddr, `TMCC_IDX_IRQMSK)) msk_q <= pwdata[1:0];
      end
   end

   // sticky status, a new event beats a write-one clear in the same cycle
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st_q <= `TMCC_RST_IRQ;
      end else begin
         st_q <= (st_q & ~((wr_go && idx_hit(paddr, `TMCC_IDX_IRQST)) ? pwdata[1:0] : 2'h0))
                 | evt_q;
      end
   end

   assign irq = |(st_q & msk_q);
   assign timer_out = tout_q;

   // channel engines; a hardware capture overrides a same-cycle data write
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < 2; i++) begin
            state_q[i] <= TMCC_IDLE;
            cnt_q[i] <= 16'h0000;
            data_q[i] <= `TMCC_RST_REG16;
         end
         en_q <= 2'h0;
         tout_q <= 2'h0;
         evt_q <= 2'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            evt_q[i] <= 1'b0;
            if (wr_data[i]) data_q[i] <= pwdata[15:0];
            if (sw_stop[i]) begin
               en_q[i] <= 1'b0;
               state_q[i] <= TMCC_IDLE;
            end else if (sw_start[i]) begin
               en_q[i] <= 1'b1;
               if (trig_f[i] == TMCC_TRIG_SW && legal[i]) begin
                  state_q[i] <= TMCC_RUN;
                  cnt_q[i] <= init_val[i];
                  evt_q[i] <= start_evt[i];
                  if (start_evt[i]) tout_q[i] <= ~tout_q[i];
               end else begin
                  state_q[i] <= TMCC_WAIT;
               end
            end else if (state_q[i] == TMCC_WAIT && trig_hit[i] && legal[i]) begin
               state_q[i] <= TMCC_RUN;
               cnt_q[i] <= init_val[i];
               evt_q[i] <= start_evt[i];
               if (start_evt[i]) tout_q[i] <= ~tout_q[i];
            end else if (state_q[i] == TMCC_RUN && legal[i]) begin
               unique case (op_f[i])
                  TMCC_OP_INTERVAL: begin
                     if (cnt_tick[i] && zero[i]) begin
                        cnt_q[i] <= load_val(data_q[i], split[i]);
                        evt_q[i] <= 1'b1;
                        tout_q[i] <= ~tout_q[i];
                     end else if (cnt_tick[i]) begin
                        cnt_q[i] <= cnt_q[i] - 16'h0001;
                     end
                  end
                  TMCC_OP_CAPTURE: begin
                     if (trig_hit[i]) begin
                        data_q[i] <= cnt_q[i];
                        cnt_q[i] <= 16'h0000;
                        evt_q[i] <= 1'b1;
                     end else if (cnt_tick[i]) begin
                        cnt_q[i] <= step_up(cnt_q[i], split[i]);
                     end
                  end
                  TMCC_OP_ONECOUNT: begin
                     if (cnt_tick[i] && zero[i]) begin
                        evt_q[i] <= 1'b1;
                        tout_q[i] <= ~tout_q[i];
                        state_q[i] <= TMCC_WAIT;
                     end else if (cnt_tick[i]) begin
                        cnt_q[i] <= cnt_q[i] - 16'h0001;
                     end
                  end
                  TMCC_OP_CAPONE: begin
                     if (opp_edge[i]) begin
                        data_q[i] <= cnt_q[i];
                        evt_q[i] <= 1'b1;
                        state_q[i] <= TMCC_WAIT;
                     end else if (cnt_tick[i]) begin
                        cnt_q[i] <= step_up(cnt_q[i], split[i]);
                     end
                  end
               endcase
            end
         end
      end
   end

   // checks on channel 1, plus the master start of channel 3; channel 3 shares the same code
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic quiet0;
   assign quiet0 = !sw_start[0] && !sw_stop[0];

   sequence run_zero_s;
      state_q[0] == TMCC_RUN && op_f[0] == TMCC_OP_INTERVAL && cnt_tick[0] && zero[0] && quiet0;
   endsequence
   sequence reload_s;
      evt_q[0] && cnt_q[0] == load_val($past(data_q[0]), $past(split[0]));
   endsequence
   sequence one_end_s;
      state_q[0] == TMCC_RUN && op_f[0] == TMCC_OP_ONECOUNT && cnt_tick[0] && zero[0] && quiet0;
   endsequence

   split_count_a: assert property (state_q[0] == TMCC_RUN && op_f[0] == TMCC_OP_CAPTURE &&
      split[0] && quiet0 && !trig_hit[0] && cnt_tick[0] |=> cnt_q[0][15:8] == 8'h00)
      else $error("8-bit count spilled into upper byte");
   sw_only_a: assert property (state_q[0] == TMCC_WAIT && trig_f[0] == TMCC_TRIG_SW &&
      quiet0 |=> state_q[0] == TMCC_WAIT)
      else $error("software trigger mode left wait without a start");
   edge_start_a: assert property (state_q[0] == TMCC_WAIT && trig_f[0] == TMCC_TRIG_EDGE &&
      valid_edge[0] && legal[0] && quiet0 |=> state_q[0] == TMCC_RUN)
      else $error("valid edge did not start the channel");
   both_capture_a: assert property (state_q[0] == TMCC_RUN && op_f[0] == TMCC_OP_CAPTURE &&
      trig_f[0] == TMCC_TRIG_BOTH && (evt.rise[0] || evt.fall[0]) && quiet0
      |=> data_q[0] == $past(cnt_q[0]) && cnt_q[0] == 16'h0000 && evt_q[0])
      else $error("edge did not capture");
   master_start_a: assert property (state_q[1] == TMCC_WAIT && trig_f[1] == TMCC_TRIG_MASTER &&
      evt_q[0] && legal[1] && !sw_start[1] && !sw_stop[1] |=> state_q[1] == TMCC_RUN)
      else $error("slave ignored master interrupt");
   interval_down_a: assert property (state_q[0] == TMCC_RUN && op_f[0] == TMCC_OP_INTERVAL &&
      cnt_tick[0] && !zero[0] && quiet0 |=> cnt_q[0] == $past(cnt_q[0]) - 16'h0001)
      else $error("interval counter did not count down");
   capture_up_a: assert property (state_q[0] == TMCC_RUN && op_f[0] == TMCC_OP_CAPTURE &&
      !split[0] && cnt_tick[0] && !trig_hit[0] && quiet0
      |=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
      else $error("capture counter did not count up");
   one_end_a: assert property (one_end_s |=> state_q[0] == TMCC_WAIT && evt_q[0]
      ##1 state_q[0] == TMCC_WAIT || !quiet0)
      else $error("one-count did not stop at zero");
   capone_a: assert property (state_q[0] == TMCC_RUN && op_f[0] == TMCC_OP_CAPONE &&
      opp_edge[0] && quiet0 |=> state_q[0] == TMCC_WAIT && data_q[0] == $past(cnt_q[0]))
      else $error("level width not captured");
   start_quiet_a: assert property (sw_start[0] && !sirq[0] |=> !evt_q[0] && $stable(tout_q[0]))
      else $error("start raised an interrupt while disabled");
   start_irq_a: assert property (sw_start[0] && sirq[0] && trig_f[0] == TMCC_TRIG_SW &&
      op_f[0] == TMCC_OP_INTERVAL |=> evt_q[0] && tout_q[0] != $past(tout_q[0]))
      else $error("start interrupt missing");
   start_en_a: assert property (sw_start[0] |=> en_q[0] ##1 (en_q[0] || $past(sw_stop[0])))
      else $error("start did not set enable status");
   stop_halt_a: assert property (sw_stop[0] |=> !en_q[0] && state_q[0] == TMCC_IDLE)
      else $error("stop did not halt the channel");
   edge_clock_a: assert property (state_q[0] == TMCC_RUN && op_f[0] == TMCC_OP_INTERVAL &&
      mode_q[0][`TMCC_MD_CCS] && !valid_edge[0] && quiet0 |=> $stable(cnt_q[0]))
      else $error("counted without a pin edge");
   period_irq_a: assert property (run_zero_s |=> reload_s ##1 st_q[0])
      else $error("period end did not reload and flag");
endmodule : tmcc_top
`default_nettype wire

// [tmcc_top_test.sv]
// self-checking bench for the timer channel block, driven over apb
// assumes the design files, tmcc_regs.svh and tmcc_pin_src are compiled first
`timescale 1ns/100ps
`default_nettype none
`include "tmcc_regs.svh"
module tmcc_top_test import tmcc_pkg::*;;
   logic clk, reset, psel, penable, pwrite, pready, pslverr, master_irq_in, irq, err;
   logic [23:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [1:0] lvl_req, pin, timer_out;
   int err_total, compares;

   tmcc_top #(.ADDR_W(24)) dut_u (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_input_pin(pin), .master_irq_in(master_irq_in),
      .timer_out(timer_out), .irq(irq));
   tmcc_pin_src pin_u (.clk(clk), .reset(reset), .lvl_req(lvl_req), .pin_q(pin));

   // 25 mhz system clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // xorshift, fixed start so every run is the same
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   function automatic logic [31:0] mode_w(input logic ccs, input logic split,
      input tmcc_trig_t trig, input tmcc_op_t op, input logic sirq);
      logic [31:0] w;
      w = 32'h00000000;
      w[`TMCC_MD_CCS] = ccs;
      w[`TMCC_MD_SPLIT] = split;
      w[`TMCC_MD_TRIG_HI:`TMCC_MD_TRIG_LO] = trig;
      w[`TMCC_MD_EDGE] = 1'b1;
      w[`TMCC_MD_OP_HI:`TMCC_MD_OP_LO] = op;
      w[`TMCC_MD_SIRQ] = sirq;
      return w;
   endfunction : mode_w

   // reload period in clocks: split keeps only the low byte
   function automatic int per(input logic [3:0] ps, input logic [15:0] d, input logic sp);
      return (1 << ps) * ((sp ? int'(d[7:0]) : int'(d)) + 1);
   endfunction : per

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : chk

   // one apb transfer; waits for pready, takes data at that edge only
   task automatic apb(input logic wr, input logic [19:0] idx, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {2'h0, idx, 2'h0};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [19:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
   endtask : wr

   task automatic rdchk(input logic [19:0] idx, input logic [31:0] exp, input string what);
      apb(1'b0, idx, 32'h00000000);
      chk(rd, exp, what);
   endtask : rdchk

   task automatic setup(input int c, input logic [31:0] md, input logic [15:0] d);
      wr(c ? `TMCC_IDX_MODE3 : `TMCC_IDX_MODE1, md);
      wr(c ? `TMCC_IDX_DATA3 : `TMCC_IDX_DATA1, {16'h0000, d});
      wr(`TMCC_IDX_START, 32'h1 << (c ? 3 : 1));
   endtask : setup

   // stop the channel and clear every status bit
   task automatic halt(input int c);
      wr(`TMCC_IDX_STOP, 32'h1 << (c ? 3 : 1));
      wr(`TMCC_IDX_IRQST, 32'h3);
   endtask : halt

   // clocks until the channel output changes, capped at 300
   task automatic tog_wait(input int c, output int cyc);
      logic old;
      old = timer_out[c];
      cyc = 0;
      do begin
         @(negedge clk);
         cyc++;
      end while (timer_out[c] === old && cyc < 300);
   endtask : tog_wait

   task automatic complete_run();
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : complete_run

   // watchdog well beyond the thousand or so clocks the tests need
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      $display("unexpected at %0t: watchdog expired", $time);
      complete_run();
   end

   // main sequence
   initial begin
      logic [31:0] r;
      logic [15:0] d;
      logic [3:0] p;
      logic o;
      int c0, c1, w;
      seed = 32'h00007FCA;
      {reset, psel, penable, pwrite, master_irq_in} = 5'h10;
      paddr = 24'h000000;
      pwdata = 32'h00000000;
      lvl_req = 2'h0;
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      rdchk(`TMCC_IDX_DATA1, 32'h0, "data1 reset");
      rdchk(`TMCC_IDX_DATA3, 32'h0, "data3 reset");
      r = rnd();
      wr(`TMCC_IDX_DATA3, r);
      rdchk(`TMCC_IDX_DATA3, {16'h0000, r[15:0]}, "data3 rw");
      apb(1'b0, 20'h00010, 32'h0);
      chk({31'h0, err}, 32'h1, "unmapped error");
      rdchk(`TMCC_IDX_START, 32'h0, "start reads zero");
      $display("test registers done");
      // interval reload: ch1 full width, ch3 split with a random high byte
      for (int c = 0; c < 2; c++) begin
         r = rnd();
         p = {3'h0, r[16]};
         d = {c[0] ? r[15:8] : 8'h00, 5'h00, r[2:0]} + 16'h0002;
         wr(`TMCC_IDX_PRESC, {28'h0, p});
         setup(c, mode_w(1'b0, c[0], TMCC_TRIG_SW, TMCC_OP_INTERVAL, 1'b0), d);
         rdchk(`TMCC_IDX_ENSTAT, 32'h1 << (c ? 3 : 1), "enable status");
         tog_wait(c, c0);
         tog_wait(c, c1);
         chk(32'(c1), 32'(per(p, d, c[0])), "reload period");
         rdchk(`TMCC_IDX_IRQST, 32'h1 << c, "period event");
         chk({31'h0, irq}, 32'h0, "masked irq");
         wr(`TMCC_IDX_IRQMSK, 32'h1 << c);
         @(negedge clk);
         chk({31'h0, irq}, 32'h1, "unmasked irq");
         halt(c);
         @(negedge clk);
         chk({31'h0, irq}, 32'h0, "cleared irq");
         rdchk(`TMCC_IDX_ENSTAT, 32'h0, "enable cleared");
         tog_wait(c, c1);
         chk(32'(c1), 32'd300, "no toggle after stop");
         wr(`TMCC_IDX_IRQMSK, 32'h0);
      end
      $display("test interval done");
      wr(`TMCC_IDX_PRESC, 32'h0);
      for (int s = 0; s < 2; s++) begin
         o = timer_out[0];
         setup(0, mode_w(1'b0, 1'b0, TMCC_TRIG_SW, TMCC_OP_INTERVAL, s[0]), 16'hFFFF);
         repeat (4) @(negedge clk);
         chk({31'h0, timer_out[0]}, {31'h0, o ^ s[0]}, "start toggle");
         rdchk(`TMCC_IDX_IRQST, 32'(s), "start event");
         halt(0);
      end
      $display("test start event done");
      // capture: one valid edge, then both edges
      for (int k = 0; k < 2; k++) begin
         setup(0, mode_w(1'b0, 1'b0, k ? TMCC_TRIG_BOTH : TMCC_TRIG_EDGE,
            TMCC_OP_CAPTURE, 1'b0), 16'h0000);
         @(posedge clk);
         lvl_req <= 2'h1;
         repeat (4) @(negedge clk);
         @(posedge clk);
         lvl_req <= 2'h0;
         repeat (4) @(negedge clk);
         rdchk(`TMCC_IDX_IRQST, 32'(k), "capture on fall");
         wr(`TMCC_IDX_IRQST, 32'h3);
         apb(1'b0, `TMCC_IDX_CNT1, 32'h0);
         r = rd;
         apb(1'b0, `TMCC_IDX_CNT1, 32'h0);
         chk({31'h0, rd > r}, 32'h1, "counts up");
         @(posedge clk);
         lvl_req <= 2'h1;
         repeat (4) @(negedge clk);
         rdchk(`TMCC_IDX_IRQST, 32'h1, "capture on rise");
         apb(1'b0, `TMCC_IDX_DATA1, 32'h0);
         chk({31'h0, rd > r}, 32'h1, "captured count");
         halt(0);
         lvl_req <= 2'h0;
      end
      $display("test capture done");
      // slave start from the master interrupt, then a software one-count
      setup(0, mode_w(1'b0, 1'b0, TMCC_TRIG_MASTER, TMCC_OP_ONECOUNT, 1'b0), 16'h0005);
      repeat (20) @(negedge clk);
      rdchk(`TMCC_IDX_IRQST, 32'h0, "waits for master");
      @(posedge clk);
      master_irq_in <= 1'b1;
      @(posedge clk);
      master_irq_in <= 1'b0;
      repeat (12) @(negedge clk);
      rdchk(`TMCC_IDX_IRQST, 32'h1, "slave one count end");
      halt(0);
      setup(1, mode_w(1'b0, 1'b0, TMCC_TRIG_SW, TMCC_OP_ONECOUNT, 1'b0), 16'h0004);
      repeat (12) @(negedge clk);
      rdchk(`TMCC_IDX_IRQST, 32'h2, "one count end");
      wr(`TMCC_IDX_IRQST, 32'h3);
      @(posedge clk);
      lvl_req <= 2'h2;
      repeat (3) @(posedge clk);
      lvl_req <= 2'h0;
      repeat (12) @(negedge clk);
      rdchk(`TMCC_IDX_IRQST, 32'h0, "pin ignored");
      halt(1);
      $display("test one count done");
      // high level width on ch3
      w = int'(rnd() % 16) + 5;
      setup(1, mode_w(1'b0, 1'b0, TMCC_TRIG_EDGE, TMCC_OP_CAPONE, 1'b0), 16'h0000);
      @(posedge clk);
      lvl_req <= 2'h2;
      repeat (w) @(posedge clk);
      lvl_req <= 2'h0;
      repeat (6) @(negedge clk);
      rdchk(`TMCC_IDX_IRQST, 32'h2, "width event");
      apb(1'b0, `TMCC_IDX_DATA3, 32'h0);
      chk({31'h0, rd >= w - 2 && rd <= w + 2}, 32'h1, "width value");
      halt(1);
      // pin edges as count clock: two valid edges end a period of data 1
      setup(0, mode_w(1'b1, 1'b0, TMCC_TRIG_SW, TMCC_OP_INTERVAL, 1'b0), 16'h0001);
      o = timer_out[0];
      repeat (30) @(negedge clk);
      chk({31'h0, timer_out[0]}, {31'h0, o}, "idle pin no count");
      repeat (2) begin
         @(posedge clk);
         lvl_req <= 2'h1;
         repeat (3) @(posedge clk);
         lvl_req <= 2'h0;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(negedge clk);
      chk({31'h0, timer_out[0]}, {31'h0, ~o}, "pin edges counted");
      halt(0);
      $display("test width and pin clock done");
      complete_run();
   end
endmodule : tmcc_top_test
`default_nettype wire
